//--- core/cgtrc_pkg.sv
// Shared constants for the charger top-off and pre-charge configuration registers
package cgtrc_pkg;
  localparam logic [7:0] TOPOFF_CTRL_ADDR = 8'h12;
  localparam logic [7:0] PRECHG_CTRL_ADDR = 8'h13;
  localparam logic [7:0] TOPOFF_CTRL_RST = 8'h04;
  localparam logic [7:0] PRECHG_CTRL_RST = 8'h08;
  localparam int TERM_CODE_LSB = 0;
  localparam int TERM_CODE_MSB = 5;
  localparam int TERM_MA_PER_CODE = 1;
  localparam int RSVD_LSB = 6;
  localparam int RSVD_MSB = 7;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR,
    ST_ACK_WR,
    ST_RD,
    ST_RD_ACK
  } cgtrc_state_type;
endpackage

//--- core/cgtrc_lock_reg.sv
// Lockable eight-bit configuration register cell
`timescale 1ns/1ps
module cgtrc_lock_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic i_write_guard,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);
  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (i_wr_en && !i_write_guard) begin
      nxt_q = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_q = q_ff;
endmodule

//--- core/cgtrc_top.sv
// Charger top-off and pre-charge control registers behind an I2C target
`timescale 1ns/1ps
module cgtrc_top #(
  parameter logic [6:0] TARGET_ADDR = cgtrc_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_charger_write_guard,
  output logic [7:0] o_charger_topoff_control,
  output logic [7:0] o_charger_precharge_control,
  output logic [5:0] o_termination_current_code,
  output logic [6:0] o_termination_current_ma
);
  cgtrc_pkg::cgtrc_state_type state_ff;
  cgtrc_pkg::cgtrc_state_type nxt_state;
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic have_ptr_ff;
  logic nxt_have_ptr;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic wr_stb_ff;
  logic nxt_wr_stb;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [7:0] wr_data_ff;
  logic [7:0] nxt_wr_data;
  logic [6:0] ma_ff;
  logic [6:0] nxt_ma;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] topoff_q;
  logic [7:0] prechg_q;
  logic [7:0] rd_data;

  assign scl_rise = i_scl && !scl_q_ff;
  assign scl_fall = !i_scl && scl_q_ff;
  assign bus_start = i_scl && scl_q_ff && sda_q_ff && !i_sda;
  assign bus_stop = i_scl && scl_q_ff && !sda_q_ff && i_sda;

  cgtrc_lock_reg #(
    .RST_VAL(cgtrc_pkg::TOPOFF_CTRL_RST)
  ) u_topoff (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr_en(wr_stb_ff && (wr_addr_ff == cgtrc_pkg::TOPOFF_CTRL_ADDR)),
    .i_write_guard(i_charger_write_guard),
    .i_wdata(wr_data_ff),
    .o_q(topoff_q)
  );

  cgtrc_lock_reg #(
    .RST_VAL(cgtrc_pkg::PRECHG_CTRL_RST)
  ) u_prechg (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr_en(wr_stb_ff && (wr_addr_ff == cgtrc_pkg::PRECHG_CTRL_ADDR)),
    .i_write_guard(i_charger_write_guard),
    .i_wdata(wr_data_ff),
    .o_q(prechg_q)
  );

  always_comb begin
    case (ptr_ff)
      cgtrc_pkg::TOPOFF_CTRL_ADDR: rd_data = topoff_q;
      cgtrc_pkg::PRECHG_CTRL_ADDR: rd_data = prechg_q;
      default: rd_data = cgtrc_pkg::UNMAPPED_RDATA;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_have_ptr = have_ptr_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_wr_stb = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    if (bus_start) begin
      nxt_state = cgtrc_pkg::ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_have_ptr = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = cgtrc_pkg::ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        cgtrc_pkg::ST_IDLE: begin
          nxt_sda_oe = 1'b0;
        end
        cgtrc_pkg::ST_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], i_sda};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == cgtrc_pkg::BITS_PER_BYTE) begin
            if (shift_ff[7:1] == TARGET_ADDR) begin
              nxt_state = cgtrc_pkg::ST_ACK_ADDR;
              nxt_sda_oe = 1'b1;
            end else begin
              nxt_state = cgtrc_pkg::ST_IDLE;
            end
          end
        end
        cgtrc_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (shift_ff[0]) begin
              nxt_state = cgtrc_pkg::ST_RD;
              nxt_shift = rd_data;
              nxt_sda_oe = !rd_data[7];
            end else begin
              nxt_state = cgtrc_pkg::ST_WR;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        cgtrc_pkg::ST_WR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], i_sda};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == cgtrc_pkg::BITS_PER_BYTE) begin
            nxt_state = cgtrc_pkg::ST_ACK_WR;
            nxt_sda_oe = 1'b1;
            if (!have_ptr_ff) begin
              nxt_ptr = shift_ff;
              nxt_have_ptr = 1'b1;
            end else begin
              nxt_wr_stb = 1'b1;
              nxt_wr_addr = ptr_ff;
              nxt_wr_data = shift_ff;
              nxt_ptr = ptr_ff + 8'h01;
            end
          end
        end
        cgtrc_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            nxt_state = cgtrc_pkg::ST_WR;
            nxt_bit_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
          end
        end
        cgtrc_pkg::ST_RD: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == cgtrc_pkg::BITS_PER_BYTE) begin
              nxt_state = cgtrc_pkg::ST_RD_ACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = !shift_ff[6];
            end
          end
        end
        cgtrc_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            nxt_ptr = ptr_ff + 8'h01;
            if (i_sda) begin
              nxt_state = cgtrc_pkg::ST_IDLE;
            end
          end else if (scl_fall) begin
            nxt_state = cgtrc_pkg::ST_RD;
            nxt_bit_cnt = 4'h0;
            nxt_shift = rd_data;
            nxt_sda_oe = !rd_data[7];
          end
        end
        default: begin
          nxt_state = cgtrc_pkg::ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    nxt_ma = 7'(int'(topoff_q[cgtrc_pkg::TERM_CODE_MSB:cgtrc_pkg::TERM_CODE_LSB])
      * cgtrc_pkg::TERM_MA_PER_CODE);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= cgtrc_pkg::ST_IDLE;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      have_ptr_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      ma_ff <= 7'(cgtrc_pkg::TOPOFF_CTRL_RST[cgtrc_pkg::TERM_CODE_MSB:cgtrc_pkg::TERM_CODE_LSB]);
    end else begin
      state_ff <= nxt_state;
      scl_q_ff <= i_scl;
      sda_q_ff <= i_sda;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      have_ptr_ff <= nxt_have_ptr;
      sda_oe_ff <= nxt_sda_oe;
      wr_stb_ff <= nxt_wr_stb;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      ma_ff <= nxt_ma;
    end
  end

  // Open drain: only ever pulls low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_ff;
  assign o_charger_topoff_control = topoff_q;
  assign o_charger_precharge_control = prechg_q;
  assign o_termination_current_code = topoff_q[cgtrc_pkg::TERM_CODE_MSB:cgtrc_pkg::TERM_CODE_LSB];
  assign o_termination_current_ma = ma_ff;
endmodule

//--- test/cgtrc_top_monitor.sv
// Checker for the charger control register outputs
`timescale 1ns/1ps
module cgtrc_top_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_charger_write_guard,
  input wire logic [7:0] o_charger_topoff_control,
  input wire logic [7:0] o_charger_precharge_control,
  input wire logic [5:0] o_termination_current_code,
  input wire logic [6:0] o_termination_current_ma
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_reset_defaults: assert property (
    $rose(i_rst_b) |-> o_charger_topoff_control == 8'h04 && o_termination_current_ma == 7'h04
    && o_charger_precharge_control[7:6] == 2'h0) else $error("reset values wrong");
  a_code_mirror: assert property (
    o_termination_current_code == o_charger_topoff_control[5:0]) else $error("code not bits 5:0");
  a_ma_scale: assert property (
    o_termination_current_ma == {1'b0, $past(o_termination_current_code)})
    else $error("ma scale");
  a_ma_range: assert property (
    o_termination_current_ma <= 7'h3f) else $error("ma above 63");
  a_guard_topoff: assert property (
    i_charger_write_guard [*3] |=> $stable(o_charger_topoff_control)) else $error("guarded 12h");
  a_guard_prechg: assert property (
    i_charger_write_guard [*3] |=> $stable(o_charger_precharge_control))
    else $error("guarded 13h");
  a_sda_open_drain: assert property (
    o_sda_o == 1'b0) else $error("sda driven high");
  c_topoff_write: cover property ($changed(o_charger_topoff_control));
  c_prechg_write: cover property ($changed(o_charger_precharge_control));
  c_guarded_ack: cover property (i_charger_write_guard && o_sda_oe);
endmodule
bind cgtrc_top cgtrc_top_monitor mon (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .i_charger_write_guard(i_charger_write_guard),
  .o_charger_topoff_control(o_charger_topoff_control),
  .o_charger_precharge_control(o_charger_precharge_control),
  .o_termination_current_code(o_termination_current_code),
  .o_termination_current_ma(o_termination_current_ma));

//--- test/cgtrc_host_model.sv
// Behavioural I2C host for the register target
`timescale 1ns/1ps
module cgtrc_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick();
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic start();
    o_sda = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b1;
    tick();
  endtask
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    tick();
    o_scl = 1'b1;
    tick();
    r = i_sda;
    o_scl = 1'b0;
    tick();
  endtask
  // One byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(mack, a);
    ack = !a;
  endtask
endmodule

//--- test/cgtrc_top_bench.sv
// Self-checking bench for the charger control registers
`timescale 1ns/1ps
module cgtrc_top_bench;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic guard = 1'b0;
  logic scl, host_sda, sda, oe;
  logic [7:0] topoff, prechg, d;
  logic [5:0] code;
  logic [6:0] ma;
  logic [7:0] vals [3] = '{8'h00, 8'h3f, 8'hc5};
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  assign sda = host_sda & !oe;
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  cgtrc_top dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda), .o_sda_o(),
    .o_sda_oe(oe), .i_charger_write_guard(guard), .o_charger_topoff_control(topoff),
    .o_charger_precharge_control(prechg), .o_termination_current_code(code),
    .o_termination_current_ma(ma));
  cgtrc_host_model host (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic ptr(input logic [7:0] a, output logic [1:0] k);
    logic [7:0] q;
    host.start();
    host.xfer({cgtrc_pkg::TARGET_ADDR_DEFAULT, 1'b0}, 1'b1, q, k[0]);
    host.xfer(a, 1'b1, q, k[1]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    logic [2:0] k;
    ptr(a, k[1:0]);
    host.xfer(v, 1'b1, q, k[2]);
    host.stop();
    chk({5'h0, k}, 8'h07);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] q;
    logic [3:0] k;
    ptr(a, k[1:0]);
    host.start();
    host.xfer({cgtrc_pkg::TARGET_ADDR_DEFAULT, 1'b1}, 1'b1, q, k[2]);
    host.xfer(8'hff, 1'b1, v, k[3]);
    host.stop();
    chk({4'h0, k}, 8'h07);
  endtask
  initial begin
    repeat (2) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    chk({1'b0, ma}, 8'h04);
    chk({prechg[7:6], 6'h0}, 8'h00);
    rd(8'h12, d);
    chk(d, 8'h04);
    foreach (vals[i]) begin
      wr(8'h12, vals[i]);
      rd(8'h12, d);
      chk(d, vals[i]);
      chk({2'h0, code}, {2'h0, vals[i][5:0]});
      chk({1'b0, ma}, {2'h0, vals[i][5:0]});
    end
    wr(8'h13, 8'hc3);
    rd(8'h13, d);
    chk(d, 8'hc3);
    guard = 1'b1;
    wr(8'h12, 8'h2a);
    wr(8'h13, 8'h11);
    rd(8'h12, d);
    chk(d, 8'hc5);
    rd(8'h13, d);
    chk(d, 8'hc3);
    guard = 1'b0;
    wr(8'h20, 8'h5a);
    rd(8'h20, d);
    chk(d, 8'h00);
    i_rst_b = 1'b0;
    @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    chk(topoff, 8'h04);
    chk(prechg, cgtrc_pkg::PRECHG_CTRL_RST);
    chk({1'b0, ma}, 8'h04);
    report_and_stop();
  end
endmodule
